// [rtl/dp_host_cfg.svh]
/*
  timing counts, field positions and reset values for the dual-port ram host.
  assumes a 20 ns system clock; the delay figures below are in nanoseconds, SYNC_LATENCY in clock cycles.
*/
`ifndef DP_HOST_CFG_SVH
`define DP_HOST_CFG_SVH

`define CLK_PERIOD_NS 20
`define SELECT_ACCESS_DELAY_NS 20
`define OUTPUT_ENABLE_DELAY_NS 12
`define CROSS_PORT_FLOW_DELAY_NS 30
`define BUSY_SETTLE_NS 20
`define WRITE_PULSE_NS 20
`define TOKEN_OFF_NS 10
`define NS_TO_CYC(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SYNC_LATENCY 4

`define ADDR_W 14
`define DATA_W 8
`define TOKEN_SEL_W 3
`define RIGHT_MAILBOX 14'h3fff
`define LEFT_MAILBOX 14'h3ffe
`define PIN_IDLE_HIGH 1'b1

`endif

// [rtl/dp_host_pkg.sv]
/*
  types shared by the dual-port ram host files.
  assumes nothing beyond a systemverilog compiler.
*/
package dp_host_pkg;
  typedef enum logic [1:0] {kind_mem_rd, kind_mem_wr, kind_tok_rd, kind_tok_wr} kind_t;
  typedef enum logic [2:0] {st_idle, st_settle, st_access, st_end, st_recover} state_t;
endpackage : dp_host_pkg

// [rtl/dp_pin_sync.sv]
/*
  three-stage pin synchroniser with agreement filter.
  assumes the pin is asynchronous to sys_clk; the level updates once stages two and three agree.
*/
`timescale 1ns/1ps
module dp_pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RESET_VAL = '0
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] level_q;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      s1_q <= RESET_VAL;
      s2_q <= RESET_VAL;
      s3_q <= RESET_VAL;
    end
    else
    begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // per bit, so one lagging line does not hold back the rest
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      always_ff @(posedge sys_clk or posedge rst)
      begin
        if (rst)
          level_q[i] <= RESET_VAL[i];
        else if (s2_q[i] == s3_q[i])
          level_q[i] <= s3_q[i];
      end
    end
  endgenerate

  assign level = level_q;
endmodule : dp_pin_sync

// [rtl/dp_host.sv]
/*
  host controller for one port of a 16k x 8 dual-port ram with mailbox and token latches.
  assumes the far device sits on its pins asynchronously; the user issues one request at a time.
*/
// What this block does
// - a write ends on the rising edge of direction, one cycle before select rises.
// - reader waits the cross-port flow delay after the other port presents data.
// - read asserts select and output enable; data valid after the later delay.
// - token read asserts token select instead of memory select, plus output enable.
// - write zero on bit 0 to request a token, read zero to confirm, one releases.
// - token chosen by low three address bits with memory select high.
// - host delays writes until the contention input has settled.
`timescale 1ns/1ps
`include "dp_host_cfg.svh"
module dp_host (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic req_valid,
  output logic req_ready,
  input wire dp_host_pkg::kind_t req_kind,
  input wire logic [`ADDR_W-1:0] req_addr,
  input wire logic [`DATA_W-1:0] req_wdata,
  output logic rsp_valid,
  output logic [`DATA_W-1:0] rsp_rdata,
  output logic rsp_contend,
  output logic mail_irq,
  output logic [`ADDR_W-1:0] mem_addr,
  output logic select_n,
  output logic rw_n,
  output logic oe_n,
  output logic token_latch_select_n,
  output logic [`DATA_W-1:0] dq_o,
  output logic dq_oe,
  input wire logic [`DATA_W-1:0] dq_i,
  input wire logic busy_n,
  input wire logic int_n
);
  import dp_host_pkg::*;

  localparam int ACE_CYC = `NS_TO_CYC(`SELECT_ACCESS_DELAY_NS);
  localparam int DOE_CYC = `NS_TO_CYC(`OUTPUT_ENABLE_DELAY_NS);
  localparam int FLOW_CYC = `NS_TO_CYC(`CROSS_PORT_FLOW_DELAY_NS);
  localparam int ACC_MAX = (ACE_CYC > DOE_CYC) ? ACE_CYC : DOE_CYC;
  localparam int WAIT_MAX = (ACC_MAX > FLOW_CYC) ? ACC_MAX : FLOW_CYC;
  localparam int READ_CYC = WAIT_MAX + `SYNC_LATENCY;
  localparam int SETTLE_CYC = `NS_TO_CYC(`BUSY_SETTLE_NS) + `SYNC_LATENCY;
  localparam int WRITE_CYC = `NS_TO_CYC(`WRITE_PULSE_NS);
  localparam int RECOVER_CYC = `NS_TO_CYC(`TOKEN_OFF_NS);

  function automatic logic is_write(input kind_t k);
    is_write = (k == kind_mem_wr) || (k == kind_tok_wr);
  endfunction : is_write

  function automatic logic is_token(input kind_t k);
    is_token = (k == kind_tok_rd) || (k == kind_tok_wr);
  endfunction : is_token

  state_t state_q;
  state_t state_d;
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  kind_t kind_q;
  kind_t kind_d;
  logic [`ADDR_W-1:0] addr_q;
  logic [`ADDR_W-1:0] addr_d;
  logic [`DATA_W-1:0] wdata_q;
  logic [`DATA_W-1:0] wdata_d;
  logic [`DATA_W-1:0] dq_s;
  logic busy_s;
  logic int_s;
  logic active_d;
  logic abort_write;
  logic capture;
  logic [7:0] oe_low_cnt_q;

  // every pin input passes the three-stage filter, data included
  dp_pin_sync #(.W(`DATA_W), .RESET_VAL('0)) u_dq_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .pin(dq_i),
    .level(dq_s)
  );

  dp_pin_sync #(.W(2), .RESET_VAL(2'h3)) u_flag_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .pin({busy_n, int_n}),
    .level({busy_s, int_s})
  );

  assign req_ready = (state_q == st_idle);
  // a memory write that still sees contention after settling is never started
  assign abort_write = (state_q == st_settle) && (cnt_q == 8'h00) && (kind_q == kind_mem_wr)
    && !busy_s;
  assign capture = (state_q == st_access) && (cnt_q == 8'h00) && !is_write(kind_q);

  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    kind_d = kind_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    case (state_q)
      st_idle:
      begin
        if (req_valid)
        begin
          kind_d = req_kind;
          addr_d = req_addr;
          wdata_d = req_wdata;
          state_d = st_settle;
          cnt_d = 8'(SETTLE_CYC - 1);
        end
      end
      st_settle:
      begin
        if (cnt_q != 8'h00)
          cnt_d = cnt_q - 8'h01;
        else if (abort_write)
        begin
          state_d = st_recover;
          cnt_d = 8'(RECOVER_CYC - 1);
        end
        else
        begin
          state_d = st_access;
          cnt_d = is_write(kind_q) ? 8'(WRITE_CYC - 1) : 8'(READ_CYC - 1);
        end
      end
      st_access:
      begin
        if (cnt_q != 8'h00)
          cnt_d = cnt_q - 8'h01;
        else if (is_write(kind_q))
          state_d = st_end;
        else
        begin
          state_d = st_recover;
          cnt_d = 8'(RECOVER_CYC - 1);
        end
      end
      st_end:
      begin
        state_d = st_recover;
        cnt_d = 8'(RECOVER_CYC - 1);
      end
      st_recover:
      begin
        if (cnt_q != 8'h00)
          cnt_d = cnt_q - 8'h01;
        else
          state_d = st_idle;
      end
      default:
      begin
        state_d = st_idle;
        cnt_d = 8'h00;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= st_idle;
      cnt_q <= 8'h00;
      kind_q <= kind_mem_rd;
      addr_q <= '0;
      wdata_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      kind_q <= kind_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
    end
  end

  assign active_d = (state_d == st_settle) || (state_d == st_access) || (state_d == st_end);

  // pins registered from the next state so they never glitch
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      select_n <= `PIN_IDLE_HIGH;
      token_latch_select_n <= `PIN_IDLE_HIGH;
      oe_n <= `PIN_IDLE_HIGH;
      rw_n <= `PIN_IDLE_HIGH;
      dq_oe <= 1'b0;
      mem_addr <= '0;
      dq_o <= '0;
    end
    else
    begin
      select_n <= !(active_d && !is_token(kind_d));
      token_latch_select_n <= !(active_d && is_token(kind_d));
      oe_n <= !(active_d && !is_write(kind_d));
      // direction rises one cycle before select, so the write ends on it
      rw_n <= !((state_d == st_access) && is_write(kind_d));
      dq_oe <= active_d && is_write(kind_d) && (state_d != st_settle);
      mem_addr <= is_token(kind_d) ? {11'h000, addr_d[`TOKEN_SEL_W-1:0]} : addr_d;
      dq_o <= is_token(kind_d) ? {7'h00, wdata_d[0]} : wdata_d;
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
      rsp_contend <= 1'b0;
    end
    else
    begin
      rsp_valid <= capture || abort_write || (state_q == st_end);
      if (capture)
        rsp_rdata <= dq_s;
      if (capture || abort_write || (state_q == st_end))
        rsp_contend <= !is_token(kind_q) && !busy_s;
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      mail_irq <= 1'b0;
    else
      mail_irq <= !int_s;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      oe_low_cnt_q <= 8'h00;
    else if (oe_n)
      oe_low_cnt_q <= 8'h00;
    else if (oe_low_cnt_q != 8'hff)
      oe_low_cnt_q <= oe_low_cnt_q + 8'h01;
  end

  sequence write_strobe;
    !rw_n ##1 rw_n;
  endsequence

  sequence contended_settle;
    abort_write;
  endsequence

  idle_pins_quiet_a: assert property (@(posedge sys_clk) disable iff (rst)
    (state_q == st_idle) && $past(state_q == st_idle) |-> select_n && token_latch_select_n
      && rw_n && !dq_oe)
    else $error("pins active while idle");

  token_select_excl_a: assert property (@(posedge sys_clk) disable iff (rst)
    !token_latch_select_n |-> select_n && (mem_addr[13:3] == 11'h000))
    else $error("token access with memory select or high address bits");

  write_end_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
    write_strobe |-> dq_oe && !(select_n && token_latch_select_n))
    else $error("write did not end on direction edge with data held");

  write_drives_a: assert property (@(posedge sys_clk) disable iff (rst)
    !rw_n |-> dq_oe && oe_n)
    else $error("write without data drive or with output enable");

  read_wait_a: assert property (@(posedge sys_clk) disable iff (rst)
    capture |-> (oe_low_cnt_q >= 8'(READ_CYC - 1)) && !oe_n)
    else $error("read captured before access and flow delay");

  contend_no_write_a: assert property (@(posedge sys_clk) disable iff (rst)
    contended_settle |=> (rw_n && !dq_oe) [*3])
    else $error("write started under contention");

  contend_report_a: assert property (@(posedge sys_clk) disable iff (rst)
    contended_settle |=> rsp_valid && rsp_contend)
    else $error("aborted write not reported as contended");

  token_off_a: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(token_latch_select_n) |-> token_latch_select_n [*2])
    else $error("token select not held off between accesses");

  irq_follow_a: assert property (@(posedge sys_clk) disable iff (rst)
    !int_s |=> mail_irq)
    else $error("interrupt flag not passed to mail_irq");

  rsp_pulse_a: assert property (@(posedge sys_clk) disable iff (rst)
    rsp_valid |=> !rsp_valid && (state_q != st_access))
    else $error("response not a single pulse");
endmodule : dp_host

// [test/far_ram.sv]
/*
  behavioural far device: 16k x 8 dual-port ram seen from the left port, plus token latches.
  assumes the host drives the left pins; the bench plays the right port through the tasks.
*/
`timescale 1ns/1ps
`include "dp_host_cfg.svh"
module far_ram (
  input wire logic [13:0] mem_addr,
  input wire logic select_n,
  input wire logic rw_n,
  input wire logic oe_n,
  input wire logic token_latch_select_n,
  input wire logic [7:0] dq_o,
  input wire logic dq_oe,
  output logic [7:0] dq_i,
  output logic busy_n,
  output logic int_n
);
  logic [7:0] mem [0:16383];
  logic [7:0] own [2];
  logic [7:0] pend [2];
  logic [13:0] far_addr;
  logic far_act;
  logic int_r_n;
  logic [7:0] last_q;
  int wr_cnt;
  wire mem_rd = !select_n && !oe_n && rw_n;
  wire tok_rd = !token_latch_select_n && !oe_n && rw_n;
  wire mem_wr = !select_n && !rw_n && dq_oe;
  wire tok_wr = !token_latch_select_n && !rw_n && dq_oe;
  wire [2:0] ti = mem_addr[2:0];
  wire [7:0] rd_val = tok_rd ? {8{!own[0][ti]}} : mem[mem_addr];
  // master mode: the model always drives the contention flag
  assign busy_n = !(far_act && !select_n && mem_addr == far_addr);
  always @*
    if (mem_rd || tok_rd)
      last_q = rd_val;
  // released lines show the inverse of the last value so a stale read cannot pass
  assign #(`SELECT_ACCESS_DELAY_NS) dq_i = (mem_rd || tok_rd) ? rd_val : ~last_q;
  initial
  begin
    foreach (mem[i]) mem[i] = 8'h00;
    own = '{8'h00, 8'h00};
    pend = '{8'h00, 8'h00};
    {far_act, far_addr, last_q} = '0;
    {int_n, int_r_n} = 2'b11;
    wr_cnt = 0;
  end
  // look a moment after the read starts, once address and contention flag have settled
  always @(posedge mem_rd)
  begin
    #1;
    if (busy_n && mem_addr == `LEFT_MAILBOX)
      int_n = 1'b1;
  end
  // every memory write strobe is counted, stored or not, so the bench can see a started write; token write strobes are not counted
  always @(negedge mem_wr)
  begin
    wr_cnt++;
    if (busy_n)
    begin
      mem[mem_addr] = dq_o;
      if (mem_addr == `RIGHT_MAILBOX)
        int_r_n = 1'b0;
    end
  end
  always @(negedge tok_wr)
    tok(0, ti, dq_o[0]);
  task automatic tok(input int s, input logic [2:0] i, input logic v);
    if (!v && !own[1-s][i])
      own[s][i] = 1'b1;
    else if (!v)
      pend[s][i] = 1'b1;
    else
    begin
      own[s][i] = 1'b0;
      pend[s][i] = 1'b0;
      if (pend[1-s][i])
        own[1-s][i] = 1'b1;
      pend[1-s][i] = 1'b0;
    end
  endtask : tok
  task automatic far_write(input logic [13:0] a, input logic [7:0] d);
    mem[a] = d;
    if (a == `LEFT_MAILBOX)
      int_n = 1'b0;
  endtask : far_write
  task automatic far_hold(input logic on, input logic [13:0] a);
    far_act = on;
    far_addr = a;
  endtask : far_hold
endmodule : far_ram

// [test/tb_top.sv]
/*
  self-checking bench for the dual-port ram host.
  assumes the far_ram model on the pins; the bench plays the right port through its tasks.
*/
`timescale 1ns/1ps
`include "dp_host_cfg.svh"
module tb_top;
  import dp_host_pkg::*;
  logic sys_clk, rst, req_valid, req_ready, rsp_valid, rsp_contend, mail_irq;
  logic select_n, rw_n, oe_n, token_latch_select_n, dq_oe, busy_n, int_n;
  kind_t req_kind;
  logic [13:0] req_addr, mem_addr;
  logic [7:0] req_wdata, rsp_rdata, dq_o, dq_i, rd;
  int bad_count, n_tests;
  dp_host u_dp_host (.sys_clk, .rst, .req_valid, .req_ready, .req_kind, .req_addr,
    .req_wdata, .rsp_valid, .rsp_rdata, .rsp_contend, .mail_irq, .mem_addr, .select_n,
    .rw_n, .oe_n, .token_latch_select_n, .dq_o, .dq_oe, .dq_i, .busy_n, .int_n);
  far_ram u_far_ram (.mem_addr, .select_n, .rw_n, .oe_n, .token_latch_select_n, .dq_o,
    .dq_oe, .dq_i, .busy_n, .int_n);
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out
  // one request, waited for under a bound; read data lands in rd
  task automatic op(input kind_t k, input logic [13:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(negedge sys_clk);
    while (req_ready !== 1'b1 && n < 40)
    begin
      @(negedge sys_clk);
      n++;
    end
    req_kind = k;
    req_addr = a;
    req_wdata = d;
    req_valid = 1'b1;
    @(negedge sys_clk);
    req_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 40)
    begin
      @(negedge sys_clk);
      n++;
    end
    chk("rsp_valid", 8'(rsp_valid), 8'h01);
    rd = rsp_rdata;
  endtask : op
  task automatic t_reset;
    chk("select_n", 8'(select_n), 8'h01);
    chk("token select", 8'(token_latch_select_n), 8'h01);
    chk("dq_oe", 8'(dq_oe), 8'h00);
    chk("req_ready", 8'(req_ready), 8'h01);
    chk("mail_irq", 8'(mail_irq), 8'h00);
  endtask : t_reset
  task automatic t_rw;
    logic [13:0] a [3] = '{14'h0000, 14'h1a5c, 14'h3ffd};
    foreach (a[i])
    begin
      op(kind_mem_wr, a[i], 8'h5a ^ a[i][7:0]);
      op(kind_mem_rd, a[i], 8'h00);
      chk("mem read", rd, 8'h5a ^ a[i][7:0]);
      chk("no contend", 8'(rsp_contend), 8'h00);
    end
    u_far_ram.far_write(14'h0100, 8'hc3);
    op(kind_mem_rd, 14'h0100, 8'h00);
    chk("far data", rd, 8'hc3);
  endtask : t_rw
  task automatic t_mail;
    int wr0;
    wr0 = u_far_ram.wr_cnt;
    u_far_ram.far_hold(1'b1, `RIGHT_MAILBOX);
    op(kind_mem_wr, `RIGHT_MAILBOX, 8'h99);
    chk("contend wr", 8'(rsp_contend), 8'h01);
    chk("write strobes", 8'(u_far_ram.wr_cnt - wr0), 8'h00);
    chk("right irq", 8'(u_far_ram.int_r_n), 8'h01);
    u_far_ram.far_hold(1'b0, 14'h0000);
    op(kind_mem_rd, `RIGHT_MAILBOX, 8'h00);
    chk("no store", rd, 8'h00);
    op(kind_mem_wr, `RIGHT_MAILBOX, 8'h11);
    chk("right irq", 8'(u_far_ram.int_r_n), 8'h00);
    u_far_ram.far_write(`LEFT_MAILBOX, 8'h77);
    repeat (10) @(negedge sys_clk);
    chk("irq set", 8'(mail_irq), 8'h01);
    op(kind_mem_rd, `RIGHT_MAILBOX, 8'h00);
    repeat (10) @(negedge sys_clk);
    chk("irq kept", 8'(mail_irq), 8'h01);
    chk("right irq kept", 8'(u_far_ram.int_r_n), 8'h00);
    u_far_ram.far_hold(1'b1, `LEFT_MAILBOX);
    op(kind_mem_rd, `LEFT_MAILBOX, 8'h00);
    chk("contend rd", 8'(rsp_contend), 8'h01);
    repeat (10) @(negedge sys_clk);
    chk("irq busy", 8'(mail_irq), 8'h01);
    u_far_ram.far_hold(1'b0, 14'h0000);
    op(kind_mem_rd, `LEFT_MAILBOX, 8'h00);
    chk("mailbox", rd, 8'h77);
    repeat (10) @(negedge sys_clk);
    chk("irq clear", 8'(mail_irq), 8'h00);
  endtask : t_mail
  task automatic t_tok;
    for (int i = 0; i < 8; i++)
    begin
      op(kind_tok_wr, {11'h7ff, 3'(i)}, 8'hfe);
      op(kind_tok_rd, 14'(i), 8'h00);
      chk("token own", rd, 8'h00);
    end
    u_far_ram.tok(1, 3'd2, 1'b0);
    op(kind_tok_rd, 14'h0002, 8'h00);
    chk("token held", rd, 8'h00);
    op(kind_tok_wr, 14'h0002, 8'h01);
    op(kind_tok_rd, 14'h0002, 8'h00);
    chk("token lost", rd, 8'hff);
  endtask : t_tok
  initial
  begin
    {req_valid, req_addr, req_wdata} = '0;
    req_kind = kind_mem_rd;
    rst = 1'b1;
    bad_count = 0;
    n_tests = 0;
    repeat (20) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;
    t_reset;
    t_rw;
    t_mail;
    t_tok;
    close_out;
  end
  // about 30 requests of under 20 cycles each; the bound leaves ample slack
  initial
  begin
    #200000;
    bad_count++;
    close_out;
  end
endmodule : tb_top
